/* common/chpf_pkg.sv */
// Package of constants and types for the lookup device host port and cascade flags
package chpf_pkg;

  // ***************************************************************
  // Widths
  // ***************************************************************
  localparam int unsigned DATA_W = 32;  // Data bus width
  localparam int unsigned PAGE_W = 4;   // Page output width
  localparam int unsigned AA_W = 13;    // Active address width
  localparam int unsigned AC_W = 13;    // Address/control bus width
  localparam int unsigned INSTR_W = 12; // Instruction field width on the data bus

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [AA_W-1:0] AA_RESET = 13'h0000;
  localparam logic [AA_W-1:0] AA_NONE = 13'h1FFF;     // All ones for no result
  localparam logic [PAGE_W-1:0] PAGE_NONE = 4'hF;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
  localparam logic [AC_W-1:0] AC_RESET = 13'h0000;
  localparam logic [1:0] SYNC_RESET = 2'h3;           // Idle-high pins settle high

  // ***************************************************************
  // States of the host cycle state machine, followed from the strobe pin
  // ***************************************************************
  typedef enum logic [2:0] {
    CHPF_ST_IDLE = 3'b001,  // Strobe high, waiting for a cycle
    CHPF_ST_LOW = 3'b010,   // Strobe low, cycle sampled and held
    CHPF_ST_END = 3'b100    // One cycle after the rising edge: results update
  } chpf_state_type;

endpackage

/* verilog/chpf_host_port.sv */
// Host control port, output latches and cascade flag logic of the lookup device
`timescale 1ns/1ps
module chpf_host_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Host control pins
  input wire logic strobe_n,
  input wire logic select_a_n,
  input wire logic select_b_n,
  input wire logic write_n,
  input wire logic out_enable_n,
  input wire logic addr_valid_n,
  input wire logic segment_sel,
  input wire logic [chpf_pkg::AC_W-1:0] ctl_addr_in,
  // Data bus, three signals
  input wire logic [chpf_pkg::DATA_W-1:0] data_in,
  output logic [chpf_pkg::DATA_W-1:0] data_out,
  output logic data_oe_n,
  // Validity line, three signals
  input wire logic entry_valid_in_n,
  output logic entry_valid_out_n,
  output logic entry_valid_oe_n,
  // Cascade chain inputs
  input wire logic match_chain_in_n,
  input wire logic full_chain_in_n,
  // Page and active address outputs with enables
  output logic [chpf_pkg::PAGE_W-1:0] page_out,
  output logic page_oe_n,
  output logic [chpf_pkg::AA_W-1:0] active_addr_out,
  output logic active_addr_oe_n,
  // Flags
  output logic match_flag_n,
  output logic full_flag_n,
  output logic multi_match_out,
  output logic multi_match_oe_n,
  // Core side: configuration
  input wire logic [chpf_pkg::PAGE_W-1:0] cfg_page,
  input wire logic cfg_soft_mode,
  input wire logic cfg_lowest_prio,
  // Core side: results of the array
  input wire logic core_is_compare,
  input wire logic core_is_nf_write,
  input wire logic core_local_match,
  input wire logic core_multi_local,
  input wire logic core_all_valid,
  input wire logic [chpf_pkg::AA_W-1:0] core_result_addr,
  input wire logic [chpf_pkg::DATA_W-1:0] core_read_data,
  input wire logic core_read_valid_n,
  // Core side: sampled cycle
  output logic cyc_start,
  output logic cyc_selected,
  output logic cyc_write,
  output logic cyc_is_address,
  output logic cyc_is_instr,
  output logic cyc_upper_half,
  output logic cyc_set_valid,
  output logic [chpf_pkg::AC_W-1:0] cyc_ctl_addr,
  output logic [chpf_pkg::DATA_W-1:0] cyc_data
);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  // Every pin passes the same two stages, so the bus pins read at a strobe
  // edge are the ones that stood beside that edge on the pins.
  // Order from the top: data, address/control, six cycle pins, then strobe,
  // output enable, match chain and full chain.
  logic [chpf_pkg::DATA_W+chpf_pkg::AC_W+9:0] pin_s1_q, pin_s1_d;
  logic [chpf_pkg::DATA_W+chpf_pkg::AC_W+9:0] pin_s2_q, pin_s2_d;

  // Next values: shift the pins in
  always_comb begin
    pin_s1_d = {data_in, ctl_addr_in, select_a_n, select_b_n, write_n, addr_valid_n,
                segment_sel, entry_valid_in_n, strobe_n, out_enable_n,
                match_chain_in_n, full_chain_in_n};
    pin_s2_d = pin_s1_q;
  end

  // Register both stages; every pin idles high, so reset to ones
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_q <= '1;
      pin_s2_q <= '1;
    end else begin
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
    end
  end

  // Synchronised levels, read only from the second stage
  logic strobe_s;
  logic oe_s;
  logic mi_s;
  logic fi_s;
  logic [chpf_pkg::DATA_W-1:0] p_dq;
  logic [chpf_pkg::AC_W-1:0] p_ac;
  logic p_sa, p_sb, p_w, p_av, p_seg, p_vb;
  assign {p_dq, p_ac, p_sa, p_sb, p_w, p_av, p_seg, p_vb,
          strobe_s, oe_s, mi_s, fi_s} = pin_s2_q;

  // ***************************************************************
  // Cycle state machine
  // ***************************************************************
  chpf_pkg::chpf_state_type state_q, state_d;
  logic sel_q, sel_d;         // Sampled selection
  logic wr_q, wr_d;           // Sampled write direction
  logic av_q, av_d;           // Sampled address-valid level
  logic seg_q, seg_d;         // Sampled segment select
  logic vb_q, vb_d;           // Sampled validity input
  logic [chpf_pkg::AC_W-1:0] ac_q, ac_d;
  logic [chpf_pkg::DATA_W-1:0] dq_q, dq_d;
  logic start_q, start_d;     // One-cycle pulse at the falling edge

  // Next state and sampled fields
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    wr_d = wr_q;
    av_d = av_q;
    seg_d = seg_q;
    vb_d = vb_q;
    ac_d = ac_q;
    dq_d = dq_q;
    start_d = 1'b0;
    case (state_q)
      chpf_pkg::CHPF_ST_IDLE: begin
        // Falling edge samples the control pins
        if (!strobe_s) begin
          state_d = chpf_pkg::CHPF_ST_LOW;
          start_d = 1'b1;
          sel_d = !p_sa || !p_sb;
          wr_d = !p_w;
          av_d = p_av;
          seg_d = p_seg;
          ac_d = p_ac;
          // Data and validity only count on a write
          if (!p_w) begin
            vb_d = !p_vb;
            dq_d = p_dq;
          end
        end
      end
      chpf_pkg::CHPF_ST_LOW: begin
        // Rising edge ends the cycle
        if (strobe_s) begin
          state_d = chpf_pkg::CHPF_ST_END;
        end
      end
      chpf_pkg::CHPF_ST_END: begin
        state_d = chpf_pkg::CHPF_ST_IDLE;
      end
      default: begin
        state_d = chpf_pkg::CHPF_ST_IDLE;
      end
    endcase
  end

  // Register the cycle state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= chpf_pkg::CHPF_ST_IDLE;
      sel_q <= 1'b0;
      wr_q <= 1'b0;
      av_q <= 1'b0;
      seg_q <= 1'b0;
      vb_q <= 1'b0;
      ac_q <= chpf_pkg::AC_RESET;
      dq_q <= chpf_pkg::DATA_RESET;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      wr_q <= wr_d;
      av_q <= av_d;
      seg_q <= seg_d;
      vb_q <= vb_d;
      ac_q <= ac_d;
      dq_q <= dq_d;
      start_q <= start_d;
    end
  end

  // Decoded cycle for the core
  assign cyc_start = start_q;
  assign cyc_selected = sel_q;
  assign cyc_write = wr_q;
  assign cyc_is_address = !cfg_soft_mode && !av_q;
  assign cyc_is_instr = cfg_soft_mode && av_q;
  assign cyc_upper_half = seg_q;
  assign cyc_set_valid = vb_q;
  assign cyc_ctl_addr = ac_q;
  // Software instruction keeps only the low field
  assign cyc_data = (cfg_soft_mode && av_q) ?
                    {{(chpf_pkg::DATA_W-chpf_pkg::INSTR_W){1'b0}},
                     dq_q[chpf_pkg::INSTR_W-1:0]} : dq_q;

  // ***************************************************************
  // Output latches and flags
  // ***************************************************************
  logic [chpf_pkg::AA_W-1:0] aa_q, aa_d;
  logic [chpf_pkg::PAGE_W-1:0] pa_q, pa_d;
  logic owner_q, owner_d;     // This device may drive the address outputs
  logic mf_q, mf_d;
  logic ff_q, ff_d;
  logic mm_q, mm_d;
  logic dq_oe_q, dq_oe_d;
  logic [chpf_pkg::DATA_W-1:0] dout_q, dout_d;
  logic vb_oe_q, vb_oe_d;
  logic vb_out_q, vb_out_d;
  logic aa_oe_q, aa_oe_d;

  // Next values of the latches; they move only in the end-of-cycle slot
  always_comb begin
    aa_d = aa_q;
    pa_d = pa_q;
    owner_d = owner_q;
    mf_d = mf_q;
    ff_d = ff_q;
    mm_d = mm_q;
    if (state_q == chpf_pkg::CHPF_ST_END) begin
      if (core_is_compare) begin
        // A deselected device shows only the match chain input
        mf_d = !((sel_q && core_local_match) || !mi_s);
        mm_d = sel_q && ((mi_s && core_multi_local) ||
                         (!mi_s && core_local_match));
        // Highest-priority responder owns the bus; none matched goes to lowest
        owner_d = (sel_q && core_local_match && mi_s) ||
                  (mi_s && !(sel_q && core_local_match) && cfg_lowest_prio);
        aa_d = (sel_q && core_local_match) ? core_result_addr :
               chpf_pkg::AA_NONE;
        pa_d = cfg_page;
      end else if (sel_q) begin
        // Memory access: show the accessed address
        owner_d = 1'b1;
        aa_d = core_result_addr;
        pa_d = cfg_page;
        // Next-free write into a full system reports all ones
        if (core_is_nf_write && core_all_valid && !fi_s) begin
          owner_d = cfg_lowest_prio;
          aa_d = chpf_pkg::AA_NONE;
        end
      end
      if (wr_q) begin
        ff_d = !(core_all_valid && !fi_s);
      end
    end
  end

  // Next values of the pin drivers
  always_comb begin
    // Data and validity driven only on a selected read while strobe low
    dq_oe_d = !(state_q == chpf_pkg::CHPF_ST_LOW && !strobe_s && sel_q && !wr_q &&
                !(cfg_soft_mode && av_q));
    dout_d = core_read_data;
    vb_oe_d = dq_oe_d;
    vb_out_d = core_read_valid_n;
    // Page and address share one enable
    // Enable follows the ownership decided in the slot that loads the address
    aa_oe_d = !(!oe_s && owner_d);
  end

  // Register outputs and latches
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aa_q <= chpf_pkg::AA_RESET;
      pa_q <= chpf_pkg::PAGE_NONE;
      owner_q <= 1'b0;
      mf_q <= 1'b1;
      ff_q <= 1'b1;
      mm_q <= 1'b0;
      dq_oe_q <= 1'b1;
      dout_q <= chpf_pkg::DATA_RESET;
      vb_oe_q <= 1'b1;
      vb_out_q <= 1'b1;
      aa_oe_q <= 1'b1;
    end else begin
      aa_q <= aa_d;
      pa_q <= pa_d;
      owner_q <= owner_d;
      mf_q <= mf_d;
      ff_q <= ff_d;
      mm_q <= mm_d;
      dq_oe_q <= dq_oe_d;
      dout_q <= dout_d;
      vb_oe_q <= vb_oe_d;
      vb_out_q <= vb_out_d;
      aa_oe_q <= aa_oe_d;
    end
  end

  // Pin outputs straight from flip-flops; the multi match line is tied low
  assign active_addr_out = aa_q;
  assign active_addr_oe_n = aa_oe_q;
  assign page_out = pa_q;
  assign page_oe_n = aa_oe_q;
  assign match_flag_n = mf_q;
  assign full_flag_n = ff_q;
  // Open drain: drive low when pulling, else released
  assign multi_match_out = 1'b0;
  assign multi_match_oe_n = !mm_q;
  assign data_out = dout_q;
  assign data_oe_n = dq_oe_q;
  assign entry_valid_out_n = vb_out_q;
  assign entry_valid_oe_n = vb_oe_q;

endmodule

/* tb/chpf_host_port_sva.sv */
// Checker of the host port pin timing and flag holding
`timescale 1ns/1ps
module chpf_host_port_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Pins watched
  input wire logic strobe_n,
  input wire logic out_enable_n,
  input wire logic data_oe_n,
  input wire logic entry_valid_oe_n,
  input wire logic page_oe_n,
  input wire logic active_addr_oe_n,
  input wire logic [3:0] page_out,
  input wire logic [12:0] active_addr_out,
  input wire logic match_flag_n,
  input wire logic full_flag_n,
  input wire logic multi_match_out,
  input wire logic multi_match_oe_n,
  input wire logic cyc_start,
  input wire logic cyc_write,
  input wire logic cyc_selected
);
  // ***************************************************************
  // Sequences
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Long enough past the synchroniser that no old update is in flight
  sequence s_low;
    !strobe_n [*5];
  endsequence
  sequence s_high;
    strobe_n [*6];
  endsequence
  // ***************************************************************
  // Properties
  // ***************************************************************
  a_data_float: assert property (s_high |-> data_oe_n && entry_valid_oe_n)
    else $error("data bus driven while strobe high");
  a_page_with_aa: assert property (page_oe_n == active_addr_oe_n)
    else $error("page and address enables differ");
  a_oe_off: assert property (out_enable_n [*5] |-> page_oe_n)
    else $error("page driven with output enable high");
  a_addr_hold: assert property (s_low |-> $stable(active_addr_out) && $stable(page_out))
    else $error("address outputs moved while strobe low");
  a_match_hold: assert property (s_low |-> $stable(match_flag_n))
    else $error("match flag moved while strobe low");
  a_full_hold: assert property (s_low |-> $stable(full_flag_n))
    else $error("full flag moved while strobe low");
  a_multi_hold: assert property (s_low |-> $stable(multi_match_oe_n) && !multi_match_out)
    else $error("multi match moved while strobe low");
  a_start_fall: assert property ($fell(strobe_n) |-> ##[1:4] cyc_start)
    else $error("no cycle start after strobe fall");
  a_start_pulse: assert property (cyc_start |=> !cyc_start)
    else $error("cycle start longer than one clock");
  a_read_only: assert property (!data_oe_n |-> cyc_selected && !cyc_write)
    else $error("data driven outside a selected read");
endmodule
bind chpf_host_port chpf_host_port_sva SVA (.core_clk, .rst, .strobe_n, .out_enable_n,
  .data_oe_n, .entry_valid_oe_n, .page_oe_n, .active_addr_oe_n, .page_out, .active_addr_out,
  .match_flag_n, .full_flag_n, .multi_match_out, .multi_match_oe_n, .cyc_start, .cyc_write,
  .cyc_selected);

/* tb/chpf_host_model.sv */
// Host controller and upstream cascade peer driving the port pins
`timescale 1ns/1ps
module chpf_host_model (
  // Clock and lines the device returns
  input wire logic core_clk,
  input wire logic [31:0] data_out,
  input wire logic data_oe_n,
  input wire logic entry_valid_out_n,
  input wire logic entry_valid_oe_n,
  // Host pins and chain inputs
  output logic strobe_n,
  output logic select_a_n,
  output logic select_b_n,
  output logic write_n,
  output logic addr_valid_n,
  output logic segment_sel,
  output logic [12:0] ctl_addr_in,
  output logic [31:0] data_in,
  output logic entry_valid_in_n,
  output logic match_chain_in_n,
  output logic full_chain_in_n
);
  logic [31:0] hd_q; // Last host data
  logic hv_q; // Last host validity
  logic wr_q; // Host drives on writes only
  // Released lines show the inverse, so a stale copy never passes
  assign data_in = !data_oe_n ? data_out : (wr_q ? hd_q : ~hd_q);
  assign entry_valid_in_n = !entry_valid_oe_n ? entry_valid_out_n : (wr_q ? hv_q : ~hv_q);
  initial begin
    {strobe_n, select_a_n, select_b_n, write_n, addr_valid_n} = 5'h1F;
    {segment_sel, ctl_addr_in, hd_q, hv_q, wr_q} = '0;
    {match_chain_in_n, full_chain_in_n} = 2'h2;
  end
  // Pins settle one clock before the strobe falls
  task automatic fall(input logic [1:0] cs, input logic w, av, seg, v, mi, fi,
    input logic [12:0] ac, input logic [31:0] d);
    @(posedge core_clk);
    {select_a_n, select_b_n} <= cs;
    write_n <= w;
    addr_valid_n <= av;
    segment_sel <= seg;
    ctl_addr_in <= ac;
    {wr_q, hd_q, hv_q} <= {!w, d, v};
    {match_chain_in_n, full_chain_in_n} <= {mi, fi};
    @(posedge core_clk);
    strobe_n <= 1'b0;
  endtask
  // High time h may be the minimum or a slow host
  task automatic rise(input int h);
    @(posedge core_clk);
    strobe_n <= 1'b1;
    repeat (h) @(posedge core_clk);
  endtask
endmodule

/* tb/chpf_host_port_bench.sv */
// Self-checking bench of the host port with a reference model of flags and outputs
`timescale 1ns/1ps
module chpf_host_port_bench;
  // ***************************************************************
  // Signals
  // ***************************************************************
  logic core_clk, rst, out_enable_n, cfg_soft_mode, cfg_lowest_prio, core_read_valid_n;
  logic core_is_compare, core_is_nf_write, core_local_match, core_multi_local, core_all_valid;
  logic [3:0] cfg_page;
  logic [12:0] core_result_addr;
  logic [31:0] core_read_data;
  wire strobe_n, select_a_n, select_b_n, write_n, addr_valid_n, segment_sel, entry_valid_in_n;
  wire match_chain_in_n, full_chain_in_n, data_oe_n, entry_valid_out_n, entry_valid_oe_n;
  wire page_oe_n, active_addr_oe_n, match_flag_n, full_flag_n, multi_match_out, multi_match_oe_n;
  wire cyc_start, cyc_selected, cyc_write, cyc_is_address, cyc_is_instr, cyc_upper_half;
  wire cyc_set_valid;
  wire [3:0] page_out;
  wire [12:0] ctl_addr_in, active_addr_out, cyc_ctl_addr;
  wire [31:0] data_in, data_out, cyc_data;
  int err_total, checked;
  chpf_host_port DUT (.core_clk, .rst, .strobe_n, .select_a_n, .select_b_n, .write_n,
    .out_enable_n, .addr_valid_n, .segment_sel, .ctl_addr_in, .data_in, .data_out, .data_oe_n,
    .entry_valid_in_n, .entry_valid_out_n, .entry_valid_oe_n, .match_chain_in_n,
    .full_chain_in_n, .page_out, .page_oe_n, .active_addr_out, .active_addr_oe_n,
    .match_flag_n, .full_flag_n, .multi_match_out, .multi_match_oe_n, .cfg_page,
    .cfg_soft_mode, .cfg_lowest_prio, .core_is_compare, .core_is_nf_write, .core_local_match,
    .core_multi_local, .core_all_valid, .core_result_addr, .core_read_data, .core_read_valid_n,
    .cyc_start, .cyc_selected, .cyc_write, .cyc_is_address, .cyc_is_instr, .cyc_upper_half,
    .cyc_set_valid, .cyc_ctl_addr, .cyc_data);
  chpf_host_model HOST (.core_clk, .data_out, .data_oe_n, .entry_valid_out_n,
    .entry_valid_oe_n, .strobe_n, .select_a_n, .select_b_n, .write_n, .addr_valid_n,
    .segment_sel, .ctl_addr_in, .data_in, .entry_valid_in_n, .match_chain_in_n,
    .full_chain_in_n);
  // ***************************************************************
  // Clock, compare, closing and watchdog
  // ***************************************************************
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // About 48 cycles of at most 16 clocks; nearly four times that is a hang
  initial begin
    #(3000 * 50);
    err_total++;
    finish_test();
  end
  // ***************************************************************
  // Main sequence: compare, write and read cycles in turn
  // ***************************************************************
  initial begin
    logic [1:0] cs;
    logic w, av, seg, v, mi, fi, lm, ml, lmx, own, rd, mf, ff, mm, cmp, nf, nfw, full;
    logic [12:0] ac;
    logic [31:0] d;
    {mf, ff, mm, err_total, checked, rst, out_enable_n} = {3'h7, 64'h0, 2'h3};
    {cfg_page, cfg_soft_mode, cfg_lowest_prio, core_is_compare, core_is_nf_write} = '0;
    {core_local_match, core_multi_local, core_all_valid, core_result_addr} = '0;
    {core_read_data, core_read_valid_n} = '0;
    void'($urandom(32'h75fb));
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chk({data_oe_n, entry_valid_oe_n, page_oe_n, match_flag_n, full_flag_n,
         multi_match_oe_n}, 6'h3F);
    chk(active_addr_out, chpf_pkg::AA_RESET);
    for (int i = 0; i < 48; i++) begin
      cmp = (i % 3 == 0);
      cs = cmp ? 2'($urandom) : 2'($urandom_range(0, 2));
      {av, seg, v, fi, lm, ml, nf, ac, d} = 52'({$urandom, $urandom});
      w = (i % 3 != 1);
      nfw = nf & !w & !cmp;
      lmx = (cs != 2'h3) & lm;
      mi = (cs != 2'h3) ? 1'($urandom) : 1'b1;
      @(posedge core_clk);
      {out_enable_n, cfg_page, cfg_soft_mode, cfg_lowest_prio} <= 7'($urandom);
      {core_all_valid, core_result_addr, core_read_valid_n} <= 15'($urandom);
      core_read_data <= $urandom;
      {core_is_compare, core_local_match, core_multi_local} <= {cmp, lm, lm & ml};
      core_is_nf_write <= nfw;
      HOST.fall(cs, w, av, seg, v, mi, fi, ac, d);
      repeat (5) @(posedge core_clk);
      #1;
      chk(cyc_selected, cs != 2'h3);
      chk(cyc_write, !w);
      chk(cyc_is_address, !cfg_soft_mode & !av);
      chk(cyc_is_instr, cfg_soft_mode & av);
      chk(cyc_upper_half, seg);
      chk(cyc_ctl_addr, ac);
      if (!w) begin
        chk(cyc_data, (cfg_soft_mode & av) ? {20'h0, d[11:0]} : d);
      end
      if (!w & !cfg_soft_mode & !av) begin
        chk(cyc_set_valid, !v);
      end
      rd = w & (cs != 2'h3) & !(cfg_soft_mode & av);
      chk(data_oe_n, !rd);
      if (rd) begin
        chk(data_out, core_read_data);
        chk(entry_valid_out_n, core_read_valid_n);
      end
      HOST.rise($urandom_range(4, 7));
      #1;
      own = 1'b1;
      full = nfw & core_all_valid & !fi;
      if (cmp) begin
        mf = !(lmx | !mi);
        mm = !(mi ? (lmx & ml) : lmx);
        own = mi & (lmx | cfg_lowest_prio);
      end else if (!w) begin
        ff = !(core_all_valid & !fi);
        own = !full | cfg_lowest_prio;
      end
      chk(match_flag_n, mf);
      chk(multi_match_oe_n, mm);
      chk(full_flag_n, ff);
      chk(active_addr_oe_n, out_enable_n | !own);
      chk(page_oe_n, out_enable_n | !own);
      if (own) begin
        chk(active_addr_out, ((cmp & !lmx) | full) ? chpf_pkg::AA_NONE : core_result_addr);
        chk(page_out, cfg_page);
      end
    end
    $display("random cycle test done");
    finish_test();
  end
endmodule
